// [frg_pkg.sv]
// Constants for the focus, RF gain and RF offset control words
package frg_pkg;

  // ---------------------------------------------------------------
  // Word layout
  // ---------------------------------------------------------------
  localparam int WORD_W  = 16;
  localparam int ADDR_W  = 4;
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 12;

  // ---------------------------------------------------------------
  // Register numbers carried in the top nibble
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_FOCUS_OFFSET_CTRL    = 4'h2;
  localparam logic [3:0] REG_RF_PATH_GAIN         = 4'h3;
  localparam logic [3:0] REG_RF_LEFT_RIGHT_OFFSET = 4'h4;
  localparam logic [3:0] REG_RF_SUM_OFFSET        = 4'h5;
  localparam logic [3:0] REG_PATH_SELECT          = 4'h8;
  localparam logic [3:0] REG_OFFSET_STATUS        = 4'h9;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ALT_TIMING_BIT   = 11;
  localparam int FOCUS_OFF_BIT    = 10;
  localparam int FOCUS_FRAC_LO    = 5;
  localparam int FOCUS_FRAC_W     = 5;
  localparam int GAIN1_LO         = 10;
  localparam int GAIN1_W          = 2;
  localparam int GAIN2_LO         = 8;
  localparam int GAIN2_W          = 2;
  localparam int GAIN3_LO         = 4;
  localparam int GAIN3_W          = 4;
  localparam int LEFT_OFFS_LO     = 6;
  localparam int LOW_OFFS_LO      = 0;
  localparam int OFFS_W           = 6;
  localparam int SEL_INPUT_BIT    = 0;
  localparam int SEL_DAC_SRC_BIT  = 1;

  // First stage gain code that the host must not use
  localparam logic [1:0] GAIN1_FORBIDDEN = 2'h3;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [4:0]  RST_FRAC   = 5'h00;
  localparam logic [1:0]  RST_GAIN2B = 2'h0;
  localparam logic [3:0]  RST_GAIN4B = 4'h0;
  localparam logic [5:0]  RST_OFFS   = 6'h00;
  localparam logic [15:0] RST_WORD   = 16'h0000;

endpackage

// [frg_regs.sv]
// Focus offset, RF gain and RF offset control register bank
//
// Operation
// - Word bits 15..12 pick the target: 2H, 3H, 4H, 5H or 8H.
// - Register 2H bit 11 enables the alternate timing mode.
// - Register 2H bit 10 low turns focus offset on, high off.
// - Register 2H bits 9..5 hold focus fraction 0 to 31/32.
// - Register 3H bits 11..10 first gain 0/6/12 dB; code 11 banned.
// - Register 3H bits 9..8 second gain 6/12/18/24 dB.
// - Register 3H bits 7..4 third gain 0 to 13 dB linear.
// - Register 4H bits 11..6 left offset, used when input select is 0.
// - Input select 1 makes the left offset field ignored.
// - Register 4H bits 5..0 right offset while input select is 0.
// - Select 1, source 0: 4H low drives phase and sum paths alike.
// - Select 1, source 1: 4H low field is ignored.
// - Register 5H bits 5..0 hold a separate sum offset code.
// - Input select 0 picks diode inputs, 1 picks the sum input.
// - DAC source 0 takes phase code from 4H low, 1 from 5H.
`timescale 1ns/1ps
`default_nettype none

module frg_regs
  import frg_pkg::*;
(
  input  wire logic                       i_ref_clk,       // 20 MHz clock
  input  wire logic                       i_reset,         // Sync reset
  input  wire logic [frg_pkg::ADDR_W-1:0] i_addr,          // Read address
  input  wire logic [frg_pkg::WORD_W-1:0] i_wdata,         // Control word
  input  wire logic                       i_wr,            // Write strobe
  input  wire logic                       i_rd,            // Read strobe
  output logic      [frg_pkg::WORD_W-1:0] o_rdata,         // Read data
  output logic                            o_alt_timing_mode, // Mode on
  output logic                            o_focus_offset_on,  // Focus DAC on
  output logic      [4:0]                 o_focus_offset_frac, // Fraction
  output logic      [1:0]                 o_rf_first_stage_gain, // Gain 1
  output logic      [1:0]                 o_rf_second_stage_gain, // Gain 2
  output logic      [3:0]                 o_rf_third_stage_gain, // Gain 3
  output logic                            o_rf_input_select, // 1: sum input
  output logic      [5:0]                 o_rf_left_offset,  // Left code
  output logic                            o_rf_left_offset_en, // Left used
  output logic      [5:0]                 o_rf_right_offset, // Right code
  output logic                            o_rf_right_offset_en, // Right used
  output logic      [5:0]                 o_phase_offset,    // Phase DAC code
  output logic      [5:0]                 o_sum_offset,      // Sum path code
  output logic                            o_sum_offset_en    // Sum used
);

  // ---------------------------------------------------------------
  // Stored fields
  // ---------------------------------------------------------------
  logic       alt_timing_mode_r,         alt_timing_mode_nxt;
  logic       focus_offset_off_r,        focus_offset_off_nxt;
  logic [4:0] focus_frac_r,              focus_frac_nxt;
  logic [1:0] rf_first_stage_gain_r,     rf_first_stage_gain_nxt;
  logic [1:0] rf_second_stage_gain_r,    rf_second_stage_gain_nxt;
  logic [3:0] rf_third_stage_gain_r,     rf_third_stage_gain_nxt;
  logic [5:0] rf_left_offset_r,          rf_left_offset_nxt;
  logic [5:0] low_offset_r,              low_offset_nxt;
  logic [5:0] rf_sum_offset_code_r,      rf_sum_offset_code_nxt;
  logic       rf_input_select_r,         rf_input_select_nxt;
  logic       phase_offset_dac_source_r, phase_offset_dac_source_nxt;

  logic [3:0] word_reg;
  logic [1:0] gain1_in;

  assign word_reg = i_wdata[ADDR_HI:ADDR_LO];
  assign gain1_in = i_wdata[GAIN1_LO +: GAIN1_W];

  // Field update from routed control words
  always_comb begin
    alt_timing_mode_nxt         = alt_timing_mode_r;
    focus_offset_off_nxt        = focus_offset_off_r;
    focus_frac_nxt              = focus_frac_r;
    rf_first_stage_gain_nxt     = rf_first_stage_gain_r;
    rf_second_stage_gain_nxt    = rf_second_stage_gain_r;
    rf_third_stage_gain_nxt     = rf_third_stage_gain_r;
    rf_left_offset_nxt          = rf_left_offset_r;
    low_offset_nxt              = low_offset_r;
    rf_sum_offset_code_nxt      = rf_sum_offset_code_r;
    rf_input_select_nxt         = rf_input_select_r;
    phase_offset_dac_source_nxt = phase_offset_dac_source_r;
    if (i_wr) begin
      case (word_reg)
        REG_FOCUS_OFFSET_CTRL: begin
          alt_timing_mode_nxt  = i_wdata[ALT_TIMING_BIT];
          focus_offset_off_nxt = i_wdata[FOCUS_OFF_BIT];
          focus_frac_nxt = i_wdata[FOCUS_FRAC_LO +: FOCUS_FRAC_W];
        end
        REG_RF_PATH_GAIN: begin
          // Forbidden first stage code keeps the previous gain
          if (gain1_in != GAIN1_FORBIDDEN) begin
            rf_first_stage_gain_nxt = gain1_in;
          end
          rf_second_stage_gain_nxt =
            i_wdata[GAIN2_LO +: GAIN2_W];
          rf_third_stage_gain_nxt =
            i_wdata[GAIN3_LO +: GAIN3_W];
        end
        REG_RF_LEFT_RIGHT_OFFSET: begin
          rf_left_offset_nxt = i_wdata[LEFT_OFFS_LO +: OFFS_W];
          low_offset_nxt     = i_wdata[LOW_OFFS_LO +: OFFS_W];
        end
        REG_RF_SUM_OFFSET: begin
          // Bits 11..6 are not stored
          rf_sum_offset_code_nxt =
            i_wdata[LOW_OFFS_LO +: OFFS_W];
        end
        REG_PATH_SELECT: begin
          rf_input_select_nxt         = i_wdata[SEL_INPUT_BIT];
          phase_offset_dac_source_nxt = i_wdata[SEL_DAC_SRC_BIT];
        end
        default: begin
          alt_timing_mode_nxt = alt_timing_mode_r;
        end
      endcase
    end
  end

  // Field registers
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      alt_timing_mode_r         <= 1'b0;
      focus_offset_off_r        <= 1'b0;
      focus_frac_r              <= RST_FRAC;
      rf_first_stage_gain_r     <= RST_GAIN2B;
      rf_second_stage_gain_r    <= RST_GAIN2B;
      rf_third_stage_gain_r     <= RST_GAIN4B;
      rf_left_offset_r          <= RST_OFFS;
      low_offset_r              <= RST_OFFS;
      rf_sum_offset_code_r      <= RST_OFFS;
      rf_input_select_r         <= 1'b0;
      phase_offset_dac_source_r <= 1'b0;
    end else begin
      alt_timing_mode_r         <= alt_timing_mode_nxt;
      focus_offset_off_r        <= focus_offset_off_nxt;
      focus_frac_r              <= focus_frac_nxt;
      rf_first_stage_gain_r     <= rf_first_stage_gain_nxt;
      rf_second_stage_gain_r    <= rf_second_stage_gain_nxt;
      rf_third_stage_gain_r     <= rf_third_stage_gain_nxt;
      rf_left_offset_r          <= rf_left_offset_nxt;
      low_offset_r              <= low_offset_nxt;
      rf_sum_offset_code_r      <= rf_sum_offset_code_nxt;
      rf_input_select_r         <= rf_input_select_nxt;
      phase_offset_dac_source_r <= phase_offset_dac_source_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Effective settings, one cycle after the stored fields
  // ---------------------------------------------------------------
  logic       eff_alt_nxt, eff_focus_on_nxt, eff_left_en_nxt;
  logic       eff_right_en_nxt, eff_sum_en_nxt;
  logic [4:0] eff_frac_nxt;
  logic [5:0] eff_left_nxt, eff_right_nxt, eff_phase_nxt, eff_sum_nxt;

  // Offset routing by input select and DAC source
  always_comb begin
    eff_alt_nxt      = alt_timing_mode_r;
    eff_focus_on_nxt = ~focus_offset_off_r;
    eff_frac_nxt     = focus_frac_r;
    eff_left_en_nxt  = ~rf_input_select_r;
    eff_right_en_nxt = ~rf_input_select_r;
    eff_left_nxt     = RST_OFFS;
    eff_right_nxt    = RST_OFFS;
    eff_sum_nxt      = RST_OFFS;
    eff_sum_en_nxt   = 1'b0;
    if (!rf_input_select_r) begin
      eff_left_nxt  = rf_left_offset_r;
      eff_right_nxt = low_offset_r;
    end else if (!phase_offset_dac_source_r) begin
      // Left field ignored in sum input mode
      eff_sum_nxt    = low_offset_r;
      eff_sum_en_nxt = 1'b1;
    end
    // Phase DAC code source
    if (phase_offset_dac_source_r) begin
      eff_phase_nxt = rf_sum_offset_code_r;
    end else begin
      eff_phase_nxt = low_offset_r;
    end
  end

  // Output registers
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_alt_timing_mode      <= 1'b0;
      o_focus_offset_on      <= 1'b0;
      o_focus_offset_frac    <= RST_FRAC;
      o_rf_first_stage_gain  <= RST_GAIN2B;
      o_rf_second_stage_gain <= RST_GAIN2B;
      o_rf_third_stage_gain  <= RST_GAIN4B;
      o_rf_input_select      <= 1'b0;
      o_rf_left_offset       <= RST_OFFS;
      o_rf_left_offset_en    <= 1'b0;
      o_rf_right_offset      <= RST_OFFS;
      o_rf_right_offset_en   <= 1'b0;
      o_phase_offset         <= RST_OFFS;
      o_sum_offset           <= RST_OFFS;
      o_sum_offset_en        <= 1'b0;
    end else begin
      o_alt_timing_mode      <= eff_alt_nxt;
      o_focus_offset_on      <= eff_focus_on_nxt;
      o_focus_offset_frac    <= eff_frac_nxt;
      o_rf_first_stage_gain  <= rf_first_stage_gain_r;
      o_rf_second_stage_gain <= rf_second_stage_gain_r;
      o_rf_third_stage_gain  <= rf_third_stage_gain_r;
      o_rf_input_select      <= rf_input_select_r;
      o_rf_left_offset       <= eff_left_nxt;
      o_rf_left_offset_en    <= eff_left_en_nxt;
      o_rf_right_offset      <= eff_right_nxt;
      o_rf_right_offset_en   <= eff_right_en_nxt;
      o_phase_offset         <= eff_phase_nxt;
      o_sum_offset           <= eff_sum_nxt;
      o_sum_offset_en        <= eff_sum_en_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] rdata_nxt;

  // Read back of stored words; unmapped reads return zero
  always_comb begin
    rdata_nxt = RST_WORD;
    if (i_rd) begin
      case (i_addr)
        REG_FOCUS_OFFSET_CTRL: begin
          rdata_nxt[ADDR_HI:ADDR_LO]          = REG_FOCUS_OFFSET_CTRL;
          rdata_nxt[ALT_TIMING_BIT]           = alt_timing_mode_r;
          rdata_nxt[FOCUS_OFF_BIT]            = focus_offset_off_r;
          rdata_nxt[FOCUS_FRAC_LO +: FOCUS_FRAC_W] = focus_frac_r;
        end
        REG_RF_PATH_GAIN: begin
          rdata_nxt[ADDR_HI:ADDR_LO]        = REG_RF_PATH_GAIN;
          rdata_nxt[GAIN1_LO +: GAIN1_W]    = rf_first_stage_gain_r;
          rdata_nxt[GAIN2_LO +: GAIN2_W]    = rf_second_stage_gain_r;
          rdata_nxt[GAIN3_LO +: GAIN3_W]    = rf_third_stage_gain_r;
        end
        REG_RF_LEFT_RIGHT_OFFSET: begin
          rdata_nxt[ADDR_HI:ADDR_LO]        = REG_RF_LEFT_RIGHT_OFFSET;
          rdata_nxt[LEFT_OFFS_LO +: OFFS_W] = rf_left_offset_r;
          rdata_nxt[LOW_OFFS_LO +: OFFS_W]  = low_offset_r;
        end
        REG_RF_SUM_OFFSET: begin
          rdata_nxt[ADDR_HI:ADDR_LO]        = REG_RF_SUM_OFFSET;
          rdata_nxt[LOW_OFFS_LO +: OFFS_W]  = rf_sum_offset_code_r;
        end
        REG_PATH_SELECT: begin
          rdata_nxt[ADDR_HI:ADDR_LO]        = REG_PATH_SELECT;
          rdata_nxt[SEL_INPUT_BIT]          = rf_input_select_r;
          rdata_nxt[SEL_DAC_SRC_BIT]        = phase_offset_dac_source_r;
        end
        REG_OFFSET_STATUS: begin
          rdata_nxt[ADDR_HI:ADDR_LO]        = REG_OFFSET_STATUS;
          rdata_nxt[0]                      = o_rf_left_offset_en;
          rdata_nxt[1]                      = o_rf_right_offset_en;
          rdata_nxt[2]                      = o_sum_offset_en;
          rdata_nxt[3]                      = o_focus_offset_on;
        end
        default: begin
          rdata_nxt = RST_WORD;
        end
      endcase
    end
  end

  // Read data register, valid only the cycle after the strobe
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_rdata <= RST_WORD;
    end else begin
      o_rdata <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_route_focus;
    @(posedge i_ref_clk) disable iff (i_reset)
    (i_wr && word_reg == REG_FOCUS_OFFSET_CTRL) |=> ##1
    (o_focus_offset_frac == $past(i_wdata[9:5], 2));
  endproperty
  a_route_focus: assert property (p_route_focus)
    else $error("focus fraction not taken from routed word");

  property p_alt_mode;
    @(posedge i_ref_clk) disable iff (i_reset)
    (i_wr && word_reg == REG_FOCUS_OFFSET_CTRL) |=> ##1
    (o_alt_timing_mode == $past(i_wdata[11], 2));
  endproperty
  a_alt_mode: assert property (p_alt_mode)
    else $error("alternate timing mode differs from bit 11");

  property p_focus_inv;
    @(posedge i_ref_clk) disable iff (i_reset)
    (i_wr && word_reg == REG_FOCUS_OFFSET_CTRL) |=> ##1
    (o_focus_offset_on != $past(i_wdata[10], 2));
  endproperty
  a_focus_inv: assert property (p_focus_inv)
    else $error("focus offset enable sense not inverted");

  property p_gain1_hold;
    @(posedge i_ref_clk) disable iff (i_reset)
    (i_wr && word_reg == REG_RF_PATH_GAIN && gain1_in == GAIN1_FORBIDDEN)
    |=> ##1 $stable(o_rf_first_stage_gain);
  endproperty
  a_gain1_hold: assert property (p_gain1_hold)
    else $error("forbidden first gain code was applied");

  property p_gain23;
    @(posedge i_ref_clk) disable iff (i_reset)
    (i_wr && word_reg == REG_RF_PATH_GAIN) |=> ##1
    ({o_rf_second_stage_gain, o_rf_third_stage_gain}
      == $past(i_wdata[9:4], 2));
  endproperty
  a_gain23: assert property (p_gain23)
    else $error("second or third gain not taken");

  property p_left_ignored;
    @(posedge i_ref_clk) disable iff (i_reset)
    o_rf_input_select |-> (!o_rf_left_offset_en && !o_rf_right_offset_en);
  endproperty
  a_left_ignored: assert property (p_left_ignored)
    else $error("left or right offset used with sum input");

  property p_same_value;
    @(posedge i_ref_clk) disable iff (i_reset)
    o_sum_offset_en |-> (o_sum_offset == o_phase_offset);
  endproperty
  a_same_value: assert property (p_same_value)
    else $error("phase and sum offsets differ");

  property p_src_5h;
    @(posedge i_ref_clk) disable iff (i_reset)
    phase_offset_dac_source_r |=>
    (o_phase_offset == $past(rf_sum_offset_code_r));
  endproperty
  a_src_5h: assert property (p_src_5h)
    else $error("phase code not taken from sum register");

  property p_unmapped;
    @(posedge i_ref_clk) disable iff (i_reset)
    (!i_rd || i_addr > REG_OFFSET_STATUS) |=> (o_rdata == RST_WORD);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("read data not zero outside a read");

endmodule

`default_nettype wire

// [frg_host_model.sv]
// Host model that writes and reads the control words
`timescale 1ns/1ps
`default_nettype none

module frg_host_model
  import frg_pkg::*;
(
  input  wire logic                       i_ref_clk, // Bus clock
  input  wire logic [frg_pkg::WORD_W-1:0] i_rdata,   // Read data
  output logic      [frg_pkg::ADDR_W-1:0] o_addr,    // Read address
  output logic      [frg_pkg::WORD_W-1:0] o_wdata,   // Control word
  output logic                            o_wr,      // Write strobe
  output logic                            o_rd       // Read strobe
);
  // ---------------------------------------------------------------
  // Idle bus
  // ---------------------------------------------------------------
  // Quiet bus at time zero
  initial begin
    o_addr  = 4'h0;
    o_wdata = 16'h0000;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // ---------------------------------------------------------------
  // Transfers
  // ---------------------------------------------------------------
  // Back-to-back writes, strobe held across the burst
  task automatic send(input logic [15:0] q[$], input bit bad_ok);
    logic [15:0] w;
    w = 16'h0000;
    @(posedge i_ref_clk);
    foreach (q[k]) begin
      w = q[k];
      // Banned first gain code only when a test asks for it
      if (!bad_ok && w[15:12] == REG_RF_PATH_GAIN &&
          w[11:10] == GAIN1_FORBIDDEN)
        w[11] = 1'b0;
      o_wdata <= w;
      o_wr    <= 1'b1;
      @(posedge i_ref_clk);
    end
    o_wr    <= 1'b0;
    o_wdata <= ~w; // Released bus shows no stale word
  endtask

  // One read, data taken in the cycle after the strobe
  task automatic fetch(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_ref_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask
endmodule

`default_nettype wire

// [focus_rf_gain_offset_regs_tb.sv]
// Self-checking bench for the focus and RF control registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

module focus_rf_gain_offset_regs_tb;
  import frg_pkg::*;
  localparam int LIMIT = 20000; // Far above the planned run
  logic        i_ref_clk = 1'b0;
  logic        i_reset   = 1'b1;
  logic [3:0]  addr;
  logic [15:0] wdata, o_rdata;
  logic        wr, rd, o_alt, o_fon, o_sel, o_len, o_ren, o_sen;
  logic [4:0]  o_frac;
  logic [1:0]  o_g1, o_g2;
  logic [3:0]  o_g3;
  logic [5:0]  o_left, o_right, o_phase, o_sum;
  int          n_fail = 0, checks = 0, cyc = 0;
  // Expected register contents
  logic        alt, fo, sel, src;
  logic [4:0]  fr;
  logic [1:0]  g1, g2;
  logic [3:0]  g3;
  logic [5:0]  lf, lo, sm;

  // ---------------------------------------------------------------
  // Clock, design and host
  // ---------------------------------------------------------------
  // 20 MHz clock
  always #25 i_ref_clk = ~i_ref_clk;

  frg_regs frg_regs_inst (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(o_rdata),
    .o_alt_timing_mode(o_alt), .o_focus_offset_on(o_fon),
    .o_focus_offset_frac(o_frac), .o_rf_first_stage_gain(o_g1),
    .o_rf_second_stage_gain(o_g2), .o_rf_third_stage_gain(o_g3),
    .o_rf_input_select(o_sel), .o_rf_left_offset(o_left),
    .o_rf_left_offset_en(o_len), .o_rf_right_offset(o_right),
    .o_rf_right_offset_en(o_ren), .o_phase_offset(o_phase),
    .o_sum_offset(o_sum), .o_sum_offset_en(o_sen)
  );

  frg_host_model frg_host_model_inst (
    .i_ref_clk(i_ref_clk), .i_rdata(o_rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd)
  );

  // ---------------------------------------------------------------
  // Expectations
  // ---------------------------------------------------------------
  // Update the expected fields for one accepted word
  function automatic void apply(input logic [15:0] w);
    case (w[15:12])
      4'h2: {alt, fo, fr} = w[11:5];
      4'h3: begin
        if (w[11:10] != 2'h3) g1 = w[11:10];
        {g2, g3} = w[9:4];
      end
      4'h4: {lf, lo} = w[11:0];
      4'h5: sm = w[5:0];
      4'h8: {src, sel} = w[1:0];
      default: ;
    endcase
  endfunction

  // Expected read data per address
  function automatic logic [15:0] rb(input logic [3:0] a);
    case (a)
      4'h2: rb = {a, alt, fo, fr, 5'h00};
      4'h3: rb = {a, g1, g2, g3, 4'h0};
      4'h4: rb = {a, lf, lo};
      4'h5: rb = {a, 6'h00, sm};
      4'h8: rb = {a, 10'h000, src, sel};
      4'h9: rb = {a, 8'h00, ~fo, sel & ~src, ~sel, ~sel};
      default: rb = 16'h0000;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  // Compare every output except o_rdata once the settings have landed
  task automatic check_all;
    logic on;
    on = sel & ~src;
    repeat (3) @(posedge i_ref_clk);
    #1;
    `CHK("alt mode", alt, o_alt)
    `CHK("focus on", ~fo, o_fon)
    `CHK("focus frac", fr, o_frac)
    `CHK("gain 1", g1, o_g1)
    `CHK("gain 2", g2, o_g2)
    `CHK("gain 3", g3, o_g3)
    `CHK("input sel", sel, o_sel)
    `CHK("left", sel ? 6'h00 : lf, o_left)
    `CHK("left en", ~sel, o_len)
    `CHK("right", sel ? 6'h00 : lo, o_right)
    `CHK("right en", ~sel, o_ren)
    `CHK("phase", src ? sm : lo, o_phase)
    `CHK("sum", on ? lo : 6'h00, o_sum)
    `CHK("sum en", on, o_sen)
  endtask

  // Write a burst, then check all outputs except o_rdata
  task automatic wr_chk(input logic [15:0] q[$], input bit bad_ok);
    frg_host_model_inst.send(q, bad_ok);
    foreach (q[k]) apply(q[k]);
    check_all();
  endtask

  // Read back, then check the data drop to zero
  task automatic read_chk(input logic [3:0] a);
    logic [15:0] d;
    frg_host_model_inst.fetch(a, d);
    `CHK("rdata", rb(a), d)
    @(posedge i_ref_clk);
    #1;
    `CHK("rdata idle", 16'h0000, o_rdata)
  endtask

  // Reset for n cycles and expect cleared fields
  task automatic do_reset(input int n);
    i_reset <= 1'b1;
    repeat (n) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    {alt, fo, fr, g1, g2, g3, lf, lo, sm, sel, src} = '0;
    check_all();
  endtask

  // Report counts and verdict, then stop
  task automatic wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Cut a hang short
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [15:0] q[$];
    logic [15:0] w;
    logic [3:0]  nib [6];
    int unsigned s;
    nib = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'hB};
    s = $urandom(36);
    do_reset(20);
    wr_chk('{16'h2BE0}, 1'b0);
    wr_chk('{16'h241F}, 1'b0);
    read_chk(4'h2);
    for (int i = 0; i < 12; i++)
      wr_chk('{{4'h3, 2'(i%3), 2'(i/3), 4'(i*5), 4'hF}}, 1'b0);
    wr_chk('{16'h3C50}, 1'b1);
    read_chk(4'h3);
    // Every input select and DAC source pairing
    for (int m = 0; m < 4; m++) begin
      wr_chk('{{4'h8, 10'h000, 2'(m)}, {4'h4, 12'($urandom)},
               {4'h5, 6'h3F, 6'($urandom)}}, 1'b0);
      read_chk(4'h4);
      read_chk(4'h5);
      read_chk(4'h8);
      read_chk(4'h9);
    end
    // Words for other registers change nothing here
    for (int n = 0; n < 16; n++)
      if (!(n inside {2, 3, 4, 5, 8})) begin
        wr_chk('{{4'(n), 12'($urandom)}}, 1'b0);
        read_chk(4'(n));
      end
    do_reset(2);
    read_chk(4'h9);
    // Random bursts of legal and foreign words
    for (int r = 0; r < 150; r++) begin
      q = {};
      repeat (1 + $urandom_range(2)) begin
        w = 16'($urandom);
        w[15:12] = nib[$urandom_range(5)];
        if (w[15:12] == 4'h3 && w[11:10] == 2'h3) w[11] = 1'b0;
        q.push_back(w);
      end
      wr_chk(q, 1'b0);
      read_chk(nib[$urandom_range(4)]);
    end
    wrap_up();
  end
endmodule

`default_nettype wire
